// ---- verification/mrs_phy_model.sv ----
// mii far-side model: answers a transmit end with a collision test pulse
`timescale 1ns/1ns
`default_nettype none
module mrs_phy_model (
  input  wire logic        clock,
  input  wire logic        tx_en_pin,
  input  wire logic [15:0] delay_cyc,
  output var  logic        collision_indication
);
  logic tx_q = 1'b0;
  int   cnt = -1;
  initial collision_indication = 1'b0;
  // a long delay stands for a phy whose test pulse is late or missing
  always @(posedge clock) begin
    tx_q <= tx_en_pin;
    if (tx_q && !tx_en_pin) cnt <= 0;
    else if (cnt >= 0 && cnt < 4000) cnt <= cnt + 1;
    collision_indication <= cnt >= int'(delay_cyc) && cnt < int'(delay_cyc) + 4;
  end
endmodule // mrs_phy_model
`default_nettype wire

// ---- verification/mrs_rx_err_stats_props.sv ----
// assertion checker for the receive error statistics block
`timescale 1ns/1ns
`default_nettype none
module mrs_rx_err_stats_props
  import mrs_pkg::*;
#(
  parameter int unsigned CNT_W = MRS_CNT_W,
  parameter int unsigned LEN_W = MRS_LEN_W
) (
  input wire logic             clock,
  input wire logic             srst,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  input wire logic             rx_frame_done,
  input wire logic [LEN_W-1:0] rx_frame_len,
  input wire logic [LEN_W-1:0] rx_len_type,
  input wire logic             rx_crc_err,
  input wire logic             rx_align_err,
  input wire logic             rx_sym_err
);
  // ----------------------------------------------------------------
  // bus phase and config shadow
  // ----------------------------------------------------------------
  logic       take, err, rd_d, rd_q, wr_d, wr_q;
  logic [7:0] a_d, a_q;
  logic [1:0] cfg_d, cfg_q;
  logic [4:0] ev_d, ev_q;
  logic [15:0] lim;
  function automatic logic cnt_at(input logic [7:0] a);
    return a <= 8'h10 && a[1:0] == 2'h0 && a != 8'h0C;
  endfunction
  always_comb begin
    take = hsel && hready && htrans[1];
    rd_d = take && !hwrite;
    wr_d = take && hwrite;
    a_d = (|haddr[31:8]) ? 8'hFF : haddr[7:0];
    cfg_d = cfg_q;
    if (wr_q && a_q == 8'h14) cfg_d = {hwdata[CFG_LEN_CHECK_BIT], hwdata[CFG_BIG_FRAMES_BIT]};
    lim = cfg_q[0] ? FRAME_MAX_BIG : FRAME_MAX_STD;
    err = rx_crc_err || rx_align_err || rx_sym_err;
    ev_d = 5'h00;
    ev_d[0] = rx_frame_done && !err && rx_frame_len > lim;
    ev_d[1] = rx_frame_done && err && rx_frame_len > lim;
    ev_d[2] = rx_frame_done && !err && rx_frame_len < FRAME_MIN;
    ev_d[4] = rx_frame_done && cfg_q[1] && rx_frame_len < rx_len_type
              && rx_len_type < TYPE_ID_MIN && rx_frame_len <= lim;
  end
  always_ff @(posedge clock) begin
    rd_q <= srst ? 1'b0 : rd_d;
    wr_q <= srst ? 1'b0 : wr_d;
    a_q <= a_d;
    cfg_q <= srst ? 2'h0 : cfg_d;
    ev_q <= srst ? 5'h00 : ev_d;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // two reads of one counter three cycles apart: the second shows the events in between
  property p_pair(bit bump);
    rd_q && $past(rd_q, 3) && a_q == $past(a_q, 3) && cnt_at(a_q) && !$past(wr_q)
    && !$past(wr_q, 2) && !$past(wr_q, 3) && !$past(wr_q, 4)
    && !$past(ev_q[a_q[4:2]], 3) && !$past(ev_q[a_q[4:2]], 2) && $past(ev_q[a_q[4:2]]) == bump
    |-> hrdata == ((bump && $past(hrdata[7:0], 3) != 8'hFF) ? $past(hrdata, 3) + 32'h1
                   : $past(hrdata, 3));
  endproperty
  chk_ready_high: assert property (hreadyout == 1'b1)
    else $error("hreadyout dropped");
  chk_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("hresp not okay");
  chk_upper_zero: assert property (rd_q && a_q <= 8'h10 && a_q[1:0] == 2'h0 |-> hrdata[31:8] == 24'h0)
    else $error("counter upper bits not zero");
  chk_idle_zero: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("hrdata not zero outside read");
  chk_unmapped_zero: assert property (rd_q && (a_q > 8'h14 || a_q[1:0] != 2'h0) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_count_bump: assert property (p_pair(1'b1))
    else $error("counter missed its event");
  chk_count_hold: assert property (p_pair(1'b0))
    else $error("counter moved without event");
  chk_write_load: assert property ($past(wr_q, 2) && cnt_at($past(a_q, 2)) && rd_q
    && a_q == $past(a_q, 2) && !$past(wr_q) && $past(ev_q) == 5'h00 && ev_q == 5'h00
    |-> hrdata == {24'h0, $past(hwdata[7:0], 2)})
    else $error("written counter value not read back");
  chk_cfg_mask: assert property (rd_q && a_q == 8'h14 |-> (hrdata & ~CFG_WR_MASK) == 32'h0)
    else $error("config unused bits not zero");
  cov_bump: cover property (rd_q && $past(rd_q, 3) && $past(ev_q[0]));
  cov_unmapped: cover property (rd_q && a_q == 8'h1C);
  cov_big_cfg: cover property (wr_q && a_q == 8'h14 && hwdata[CFG_BIG_FRAMES_BIT]);
endmodule // mrs_rx_err_stats_props
bind mrs_rx_err_stats mrs_rx_err_stats_props #(.CNT_W(CNT_W), .LEN_W(LEN_W)) u_props (
  .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .rx_frame_done(rx_frame_done), .rx_frame_len(rx_frame_len), .rx_len_type(rx_len_type),
  .rx_crc_err(rx_crc_err), .rx_align_err(rx_align_err), .rx_sym_err(rx_sym_err));
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the receive error statistics block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mrs_pkg::*;
  logic        clock = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic        rx_frame_done = 1'b0, rx_crc_err = 1'b0, rx_align_err = 1'b0, rx_sym_err = 1'b0;
  logic        tx_en_pin = 1'b0, collision_indication, big_b = 1'b0, lchk_b = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rv, seed = 32'h0001_48F1;
  logic [15:0] rx_frame_len = 16'h0, rx_len_type = 16'h0, phy_delay = 16'h0, len, lt;
  logic [7:0]  exp_cnt [5];
  logic [15:0] lens [8] = '{16'h003F, 16'h0040, 16'h05EE, 16'h05EF, 16'h0600, 16'h0601,
                            16'h0020, 16'h0640};
  logic [2:0]  idxs [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  // {expect count, full duplex, 100 Mb/s} and the phy's test pulse delay in cycles
  logic [2:0]  sq_mode [8] = '{3'b001, 3'b101, 3'b000, 3'b011, 3'b001, 3'b101, 3'b000, 3'b100};
  logic [15:0] sq_dly [8] = '{16'h0014, 16'h012C, 16'h012C, 16'h012C, 16'h005E, 16'h005F,
                             16'h03BE, 16'h03BF};
  int          fail_count = 0, check_count = 0;
  initial forever #5 clock = ~clock;
  mrs_rx_err_stats u_dut (
    .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_frame_done(rx_frame_done), .rx_frame_len(rx_frame_len),
    .rx_len_type(rx_len_type), .rx_crc_err(rx_crc_err), .rx_align_err(rx_align_err),
    .rx_sym_err(rx_sym_err), .tx_en_pin(tx_en_pin), .collision_indication(collision_indication));
  mrs_phy_model u_phy (
    .clock(clock), .tx_en_pin(tx_en_pin), .delay_cyc(phy_delay),
    .collision_indication(collision_indication));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [4:0] classify(input logic [15:0] l, t, input logic [2:0] e);
    logic [15:0] lim;
    lim = big_b ? 16'h0600 : 16'h05EE;
    classify = 5'h00;
    classify[0] = l > lim && e == 3'h0;
    classify[1] = l > lim && e != 3'h0;
    classify[2] = l < 16'h0040 && e == 3'h0;
    classify[4] = lchk_b && l < t && t < 16'h0600 && l <= lim;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, want);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one edge at which hready is seen high, bounded
  task automatic edge_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    edge_rdy();
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic rdchk(input string nm, input logic [31:0] a, want);
    bus(1'b0, a, 32'h0);
    check(nm, rd, want);
  endtask
  task automatic setcfg(input logic spd, fdx, big, lchk);
    big_b = big;
    lchk_b = lchk;
    bus(1'b1, OFS_NET_CONFIG, {15'h0, lchk, 7'h0, big, 3'h0, fdx, 3'h0, spd});
  endtask
  // one counter read, a one-cycle frame end, then the same counter read again
  task automatic frame_pair(input logic [2:0] idx, input logic [15:0] l, t, input logic [2:0] e);
    logic [4:0] v;
    rdchk("count before", {27'h0, idx, 2'h0}, {24'h0, exp_cnt[idx]});
    rx_frame_done <= 1'b1;
    rx_frame_len <= l;
    rx_len_type <= t;
    {rx_crc_err, rx_align_err, rx_sym_err} <= e;
    @(posedge clock);
    rx_frame_done <= 1'b0;
    v = classify(l, t, e);
    for (int i = 0; i < 5; i++) if (v[i] && exp_cnt[i] != 8'hFF) exp_cnt[i]++;
    rdchk("count after", {27'h0, idx, 2'h0}, {24'h0, exp_cnt[idx]});
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 7; i++) rdchk("reset value", 32'(i * 4), 32'h0);
    for (int i = 0; i < 5; i++) begin
      rv = (i == 0) ? 32'hABCD_12FE : rnd();
      bus(1'b1, 32'(i * 4), rv);
      exp_cnt[i] = rv[7:0];
      rdchk("write load", 32'(i * 4), {24'h0, rv[7:0]});
    end
    bus(1'b1, 32'h0000_001C, 32'hFFFF_FFFF);
    rdchk("unmapped", 32'h0000_001C, 32'h0);
    bus(1'b1, OFS_NET_CONFIG, 32'hFFFF_FFFF);
    rdchk("config", OFS_NET_CONFIG, CFG_WR_MASK);
    for (int n = 0; n < 120; n++) begin
      rv = rnd();
      if (n % 10 == 0) setcfg(1'b1, 1'b1, rv[8], rv[16]);
      len = (rv[2:0] == 3'h6) ? 16'(rv[26:16]) : lens[rv[2:0]];
      lt = rv[9] ? len + 16'(rv[13:10]) : 16'h05FE + 16'(rv[11:10]);
      frame_pair(idxs[rv[15:14]], len, lt, rv[31] ? rv[30:28] : 3'h0);
    end
    // test pulse: prompt, late, in window at 10 Mb/s, full duplex, then both window ends
    for (int k = 0; k < 8; k++) begin
      setcfg(sq_mode[k][0], sq_mode[k][1], 1'b0, 1'b0);
      phy_delay <= sq_dly[k];
      tx_en_pin <= 1'b1;
      repeat (30) @(posedge clock);
      tx_en_pin <= 1'b0;
      repeat (1200) @(posedge clock);
      if (sq_mode[k][2] && exp_cnt[3] != 8'hFF) exp_cnt[3]++;
      rdchk("sqe count", OFS_SQE_TEST_ERR, {24'h0, exp_cnt[3]});
    end
    for (int i = 0; i < 5; i++) rdchk("final count", 32'(i * 4), {24'h0, exp_cnt[i]});
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire

// ---- verilog/mrs_pkg.sv ----
// shared constants and types for the receive error statistics block
package mrs_pkg;

  // ----------------------------------------------------------------
  // counter and field layout
  // ----------------------------------------------------------------
  localparam int unsigned MRS_CNT_W   = 8;
  localparam int unsigned MRS_NUM_CNT = 5;
  localparam int unsigned MRS_LEN_W   = 16;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] OFS_OVERSIZE_GOOD = 32'h0000_0000;
  localparam logic [31:0] OFS_RX_JABBER     = 32'h0000_0004;
  localparam logic [31:0] OFS_UNDERSIZE     = 32'h0000_0008;
  localparam logic [31:0] OFS_SQE_TEST_ERR  = 32'h0000_000C;
  localparam logic [31:0] OFS_LEN_MISMATCH  = 32'h0000_0010;
  localparam logic [31:0] OFS_NET_CONFIG    = 32'h0000_0014;

  localparam logic [2:0] IDX_OVERSIZE_GOOD = 3'h0;
  localparam logic [2:0] IDX_RX_JABBER     = 3'h1;
  localparam logic [2:0] IDX_UNDERSIZE     = 3'h2;
  localparam logic [2:0] IDX_SQE_TEST_ERR  = 3'h3;
  localparam logic [2:0] IDX_LEN_MISMATCH  = 3'h4;
  localparam logic [2:0] IDX_NET_CONFIG    = 3'h5;

  // ----------------------------------------------------------------
  // configuration bits
  // ----------------------------------------------------------------
  localparam int unsigned CFG_SPEED_100_BIT   = 0;
  localparam int unsigned CFG_FULL_DUPLEX_BIT = 4;
  localparam int unsigned CFG_BIG_FRAMES_BIT  = 8;
  localparam int unsigned CFG_LEN_CHECK_BIT   = 16;
  localparam logic [31:0] CFG_RESET           = 32'h0000_0000;
  localparam logic [31:0] CFG_WR_MASK         = 32'h0001_0111;

  // ----------------------------------------------------------------
  // frame length limits, bytes
  // ----------------------------------------------------------------
  localparam logic [15:0] FRAME_MAX_STD = 16'h05EE;
  localparam logic [15:0] FRAME_MAX_BIG = 16'h0600;
  localparam logic [15:0] FRAME_MIN     = 16'h0040;
  localparam logic [15:0] TYPE_ID_MIN   = 16'h0600;

  // ----------------------------------------------------------------
  // sqe window timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SQE_WINDOW_BITS = 96;
  localparam int unsigned BIT_NS_100M     = 10;
  localparam int unsigned BIT_NS_10M      = 100;
  localparam int unsigned SQE_CYC_100M    = (SQE_WINDOW_BITS * BIT_NS_100M) / CLK_PERIOD_NS;
  localparam int unsigned SQE_CYC_10M     = (SQE_WINDOW_BITS * BIT_NS_10M) / CLK_PERIOD_NS;
  localparam int unsigned SQE_WIN_W       = 10;

  typedef enum logic [1:0] {
    SQE_IDLE = 2'b00,
    SQE_TX   = 2'b01,
    SQE_WAIT = 2'b10
  } mrs_sqe_state_t;

  // ----------------------------------------------------------------
  // ahb-lite encodings
  // ----------------------------------------------------------------
  localparam logic       HRESP_OKAY = 1'b0;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;

endpackage

// ---- verilog/mrs_rx_err_stats.sv ----
// receive error statistics counters with an ahb-lite register slave
`timescale 1ns/1ns
`default_nettype none
module mrs_rx_err_stats
  import mrs_pkg::*;
#(
  parameter int unsigned CNT_W = MRS_CNT_W,
  parameter int unsigned LEN_W = MRS_LEN_W
) (
  input  wire logic             clock,
  input  wire logic             srst,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output var  logic             hreadyout,
  output var  logic             hresp,
  output var  logic [31:0]      hrdata,
  // receive frame status, same clock
  input  wire logic             rx_frame_done,
  input  wire logic [LEN_W-1:0] rx_frame_len,
  input  wire logic [LEN_W-1:0] rx_len_type,
  input  wire logic             rx_crc_err,
  input  wire logic             rx_align_err,
  input  wire logic             rx_sym_err,
  // mii pins
  input  wire logic             tx_en_pin,
  input  wire logic             collision_indication
);

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic [31:0] cfg_q, cfg_d;
  logic        big_frames;
  logic        len_check_en;
  logic        full_duplex;
  logic        speed_100;

  assign big_frames   = cfg_q[CFG_BIG_FRAMES_BIT];
  assign len_check_en = cfg_q[CFG_LEN_CHECK_BIT];
  assign full_duplex  = cfg_q[CFG_FULL_DUPLEX_BIT];
  assign speed_100    = cfg_q[CFG_SPEED_100_BIT];

  // ----------------------------------------------------------------
  // frame classification
  // ----------------------------------------------------------------
  logic [LEN_W-1:0]     size_limit;
  logic                 any_err;
  logic                 oversize;
  logic                 undersize;
  logic                 len_short;
  logic                 is_type_id;
  logic                 sqe_fail;
  logic [MRS_NUM_CNT-1:0] evt;

  assign size_limit = big_frames ? LEN_W'(FRAME_MAX_BIG) : LEN_W'(FRAME_MAX_STD);
  assign any_err    = rx_crc_err | rx_align_err | rx_sym_err;
  assign oversize   = rx_frame_len > size_limit;
  assign undersize  = rx_frame_len < LEN_W'(FRAME_MIN);
  assign len_short  = rx_frame_len < rx_len_type;
  assign is_type_id = rx_len_type >= LEN_W'(TYPE_ID_MIN);

  always_comb begin
    evt                    = '0;
    evt[IDX_OVERSIZE_GOOD] = rx_frame_done & oversize & ~any_err;
    evt[IDX_RX_JABBER]     = rx_frame_done & oversize & any_err;
    evt[IDX_UNDERSIZE]     = rx_frame_done & undersize & ~any_err;
    evt[IDX_SQE_TEST_ERR]  = sqe_fail;
    // checking gated by the config bit; type ids and oversize excluded
    evt[IDX_LEN_MISMATCH]  = rx_frame_done & len_check_en
                             & len_short
                             & ~is_type_id & ~oversize;
  end

  // ----------------------------------------------------------------
  // sqe test watch
  // ----------------------------------------------------------------
  mrs_sqe_monitor #(
    .WIN_W (SQE_WIN_W)
  ) u_sqe (
    .clock         (clock),
    .srst          (srst),
    .tx_en_pin     (tx_en_pin),
    .collision_pin (collision_indication),
    .half_duplex   (~full_duplex),
    .speed_100     (speed_100),
    .sqe_fail      (sqe_fail)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic       take;
  logic       addr_hit;
  logic [2:0] addr_idx;

  assign take = hsel & hready & (htrans != HTRANS_IDLE) & htrans[1];

  always_comb begin
    addr_hit = 1'b1;
    addr_idx = IDX_OVERSIZE_GOOD;
    if (haddr == OFS_OVERSIZE_GOOD) begin
      addr_idx = IDX_OVERSIZE_GOOD;
    end else if (haddr == OFS_RX_JABBER) begin
      addr_idx = IDX_RX_JABBER;
    end else if (haddr == OFS_UNDERSIZE) begin
      addr_idx = IDX_UNDERSIZE;
    end else if (haddr == OFS_SQE_TEST_ERR) begin
      addr_idx = IDX_SQE_TEST_ERR;
    end else if (haddr == OFS_LEN_MISMATCH) begin
      addr_idx = IDX_LEN_MISMATCH;
    end else if (haddr == OFS_NET_CONFIG) begin
      addr_idx = IDX_NET_CONFIG;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // write pipeline: address phase held until the data phase
  // ----------------------------------------------------------------
  logic       wr_pend_q, wr_pend_d;
  logic [2:0] wr_idx_q, wr_idx_d;

  always_comb begin
    wr_pend_d = take & hwrite & addr_hit;
    wr_idx_d  = addr_idx;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= IDX_OVERSIZE_GOOD;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q  <= wr_idx_d;
    end
  end

  always_comb begin
    cfg_d = cfg_q;
    if (wr_pend_q && wr_idx_q == IDX_NET_CONFIG) begin
      cfg_d = hwdata & CFG_WR_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_q <= CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // statistics counters
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q [MRS_NUM_CNT];

  genvar gi;
  generate
    for (gi = 0; gi < MRS_NUM_CNT; gi++) begin : g_cnt
      logic [CNT_W-1:0] base;
      logic [CNT_W-1:0] cnt_d;
      logic             wr_hit;

      assign wr_hit = wr_pend_q & (wr_idx_q == 3'(gi));

      // a write and an event in one cycle: the event lands on top
      always_comb begin
        base  = wr_hit ? hwdata[CNT_W-1:0] : cnt_q[gi];
        cnt_d = base;
        // saturate rather than wrap, so a stuck-high count stays visible
        if (evt[gi] && base != CNT_MAX) begin
          cnt_d = base + CNT_W'(1);
        end
      end

      always_ff @(posedge clock) begin
        if (srst) begin
          cnt_q[gi] <= '0;
        end else begin
          cnt_q[gi] <= cnt_d;
        end
      end
    end
  endgenerate

  logic [CNT_W-1:0] oversize_good_count;
  logic [CNT_W-1:0] jabber_count_field;
  logic [CNT_W-1:0] undersize_count_field;
  logic [CNT_W-1:0] sqe_fail_count_field;
  logic [CNT_W-1:0] length_mismatch_field;

  assign oversize_good_count   = cnt_q[IDX_OVERSIZE_GOOD];
  assign jabber_count_field    = cnt_q[IDX_RX_JABBER];
  assign undersize_count_field = cnt_q[IDX_UNDERSIZE];
  assign sqe_fail_count_field  = cnt_q[IDX_SQE_TEST_ERR];
  assign length_mismatch_field = cnt_q[IDX_LEN_MISMATCH];

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic [31:0] hrdata_q, hrdata_d;
  logic        hreadyout_q;
  logic        hresp_q;

  // a read right behind a write to the same word sees the new data
  always_comb begin
    rd_val = '0;
    if (addr_idx == IDX_NET_CONFIG) begin
      rd_val = cfg_q;
      if (wr_pend_q && wr_idx_q == IDX_NET_CONFIG) begin
        rd_val = hwdata & CFG_WR_MASK;
      end
    end else begin
      for (int i = 0; i < MRS_NUM_CNT; i++) begin
        if (addr_idx == 3'(i)) begin
          rd_val = 32'(cnt_q[i]);
        end
      end
      if (wr_pend_q && wr_idx_q == addr_idx) begin
        rd_val = 32'(hwdata[CNT_W-1:0]);
      end
    end
  end

  always_comb begin
    hrdata_d = '0;
    if (take && !hwrite && addr_hit) begin
      hrdata_d = rd_val;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      hrdata_q    <= '0;
      hreadyout_q <= 1'b1;
      hresp_q     <= HRESP_OKAY;
    end else begin
      hrdata_q    <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q     <= HRESP_OKAY;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;

endmodule // mrs_rx_err_stats
`default_nettype wire

// ---- verilog/mrs_sqe_monitor.sv ----
// sqe test watch: flags a transmit end with no collision in the window
`timescale 1ns/1ns
`default_nettype none
module mrs_sqe_monitor
  import mrs_pkg::*;
#(
  parameter int unsigned WIN_W = SQE_WIN_W
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic tx_en_pin,
  input  wire logic collision_pin,
  input  wire logic half_duplex,
  input  wire logic speed_100,
  output var  logic sqe_fail
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic tx_s1_q, tx_s2_q, col_s1_q, col_s2_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_s1_q  <= 1'b0;
      tx_s2_q  <= 1'b0;
      col_s1_q <= 1'b0;
      col_s2_q <= 1'b0;
    end else begin
      tx_s1_q  <= tx_en_pin;
      tx_s2_q  <= tx_s1_q;
      col_s1_q <= collision_pin;
      col_s2_q <= col_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // window state machine
  // ----------------------------------------------------------------
  mrs_sqe_state_t   state_q, state_d;
  logic [WIN_W-1:0] win_q, win_d;
  logic [WIN_W-1:0] win_last;
  logic             fail_q, fail_d;

  // both pins share the same sync delay, so the window stays aligned
  assign win_last = speed_100 ? WIN_W'(SQE_CYC_100M - 1) : WIN_W'(SQE_CYC_10M - 1);

  always_comb begin
    state_d = state_q;
    win_d   = win_q;
    fail_d  = 1'b0;
    case (state_q)
      SQE_IDLE: begin
        if (tx_s2_q) state_d = SQE_TX;
      end
      SQE_TX: begin
        if (!tx_s2_q) begin
          state_d = SQE_WAIT;
          win_d   = '0;
        end
      end
      SQE_WAIT: begin
        if (col_s2_q) begin
          state_d = SQE_IDLE;
        end else if (win_q == win_last) begin
          fail_d  = 1'b1;
          state_d = SQE_IDLE;
        end else if (tx_s2_q) begin
          state_d = SQE_TX;
        end else begin
          win_d = win_q + WIN_W'(1);
        end
      end
      default: state_d = SQE_IDLE;
    endcase
    // only half duplex transmissions are watched
    if (!half_duplex) begin
      state_d = SQE_IDLE;
      fail_d  = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= SQE_IDLE;
      win_q   <= '0;
      fail_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      win_q   <= win_d;
      fail_q  <= fail_d;
    end
  end

  assign sqe_fail = fail_q;

endmodule // mrs_sqe_monitor
`default_nettype wire
